// file: hrs_home_return.sv
// Home return sequencer for one servo axis
// Behaviour
// (RULE1) On completion load the home address into the current position.
// (RULE2) After dog on, drop from homing speed to creep speed until stopping.
// (RULE3) Count type: travel set distance after dog, then home on first zero pulse.
// (RULE4) Software sets post-dog travel larger than the deceleration distance.
// (RULE5) Motor must have crossed the zero phase before homing is commanded.
// (RULE6) Dog or count start-to-stop distance must exceed one motor revolution.
// (RULE7) Data-set homing on absolute systems needs a prior zero-phase pass.
// (RULE8) Option bit set allows homing without a prior zero-pulse crossing.
// (RULE9) Configured parameter block selects the ramp and limit settings used.
// (RULE10) With retry enabled, dwell for the set time at each reversal.
// (RULE11) Retry only for dog, count and dog-cradle methods.
// (RULE12) Shift by signed amount from zero pulse: positive up, negative down.
// (RULE13) Nonzero shift runs at homing or creep speed by one select bit.
// (RULE14) Shift only for dog, count, dog-cradle and limit-combined methods.
// (RULE15) Stopper homing applies the creep torque limit while pressing.
// (RULE16) While homing is requested, a setting permits or refuses programs.
// (RULE17) Tenfold rotary mode accepts speeds up to 21474836.47 degree per minute.
// (RULE18) Software picks dog or count type for non-absolute amplifiers.
// (RULE19) Software sets home address at the upper or lower stroke limit.
// (RULE20) Refused program with homing pending raises error 121 and does not start.
// (RULE21) Creep torque limit accepts 1 to 1000 percent, defaulting to 300.
`timescale 1ns/1ps
module hrs_home_return
   import hrs_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire hrs_cfg_t cfg,
   input wire logic home_start,
   input wire logic dog_in,
   input wire logic limit_in,
   input wire logic zero_pulse,
   input wire logic stall_in,
   input wire logic step_in,
   input wire logic step_dir,
   input wire logic req_set,
   input wire logic prog_start,
   input wire logic prog_is_homing,
   output hrs_motion_t motion,
   output logic [5:0] param_block_sel,
   output logic torque_lim_en,
   output logic [9:0] torque_lim,
   output logic [31:0] cur_pos,
   output logic homing_request_flag,
   output logic busy,
   output logic home_done,
   output logic prog_accept,
   output logic err_pulse,
   output logic [7:0] err_code
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_APPROACH, ST_CREEP, ST_DOG_TRAVEL, ST_SEEK_ZERO,
      ST_RETRY_DWELL, ST_RETRY_BACK, ST_SHIFT, ST_PRESS
   } hrs_state_t;

   function automatic logic hrs_retry_ok(input logic [3:0] m);
      hrs_retry_ok = (m == METH_DOG1) || (m == METH_DOG2) || (m == METH_CNT1) ||
                     (m == METH_CNT2) || (m == METH_CNT3) || (m == METH_CRADLE);
   endfunction

   function automatic logic hrs_shift_ok(input logic [3:0] m);
      hrs_shift_ok = hrs_retry_ok(m) || (m == METH_LIMIT);
   endfunction

   function automatic logic hrs_is_count(input logic [3:0] m);
      hrs_is_count = (m == METH_CNT1) || (m == METH_CNT2) || (m == METH_CNT3);
   endfunction

   function automatic logic hrs_spd_ok(input logic [31:0] v, input logic x10);
      hrs_spd_ok = (v >= SPD_MIN) && (v <= (x10 ? SPD_MAX_X10 : SPD_MAX));
   endfunction

   hrs_state_t state, next_state;
   hrs_cfg_t act, next_act;
   hrs_motion_t next_motion;
   logic [31:0] remain, next_remain;
   logic [31:0] next_cur_pos;
   logic retry_phase, next_retry_phase;
   logic dog_seen, next_dog_seen;
   logic zp_seen, next_zp_seen;
   logic dog_q, limit_q;
   logic next_flag, next_done, next_busy;
   logic next_tq_en;
   logic [9:0] next_tq;
   logic [5:0] next_pb;
   logic seq_err, next_seq_err;
   logic [7:0] seq_code, next_seq_code;
   logic gate_err, next_gate_err, next_accept;
   logic [7:0] next_err_code;
   logic dwell_start, dwell_done;
   logic dog_rise, dog_fall, limit_hit;
   logic finish;

   assign dog_rise = dog_in && !dog_q;
   assign dog_fall = !dog_in && dog_q;
   assign limit_hit = limit_in && !limit_q;

   hrs_dwell_timer #(.CYC_PER_MS(CYC_PER_MS)) u_dwell (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .start(dwell_start),
      .ms(act.dwell_ms),
      .done(dwell_done)
   );

   always_comb begin
      next_state = state;
      next_act = act;
      next_motion = motion;
      next_remain = remain;
      next_retry_phase = retry_phase;
      next_dog_seen = dog_seen;
      next_zp_seen = zp_seen || zero_pulse;
      next_cur_pos = cur_pos;
      next_tq_en = 1'b0;
      next_tq = torque_lim;
      next_pb = param_block_sel;
      next_seq_err = 1'b0;
      next_seq_code = seq_code;
      next_busy = busy;
      dwell_start = 1'b0;
      finish = 1'b0;
      if (step_in) begin
         next_cur_pos = step_dir ? cur_pos + 32'h1 : cur_pos - 32'h1;
         if (remain != 32'h0) begin
            next_remain = remain - 32'h1;
         end
      end
      case (state)
         ST_IDLE: begin
            next_motion.run = 1'b0;
            if (home_start) begin
               if (!hrs_spd_ok(cfg.home_speed, cfg.deg_x10) ||
                   !hrs_spd_ok(cfg.creep_speed, cfg.deg_x10)) begin // RULE17
                  next_seq_err = 1'b1;
                  next_seq_code = ERR_SPEED;
               end else if (!zp_seen && !cfg.zpass_opt) begin // RULE8
                  next_seq_err = 1'b1;
                  next_seq_code = ERR_NO_ZPHASE;
               end else begin
                  next_act = cfg;
                  if (cfg.creep_tq < TQ_MIN || cfg.creep_tq > TQ_MAX) begin
                     next_act.creep_tq = TQ_DEFAULT; // RULE21
                  end
                  next_pb = cfg.param_block; // RULE9
                  next_busy = 1'b1;
                  next_retry_phase = 1'b0;
                  next_dog_seen = 1'b0;
                  next_motion.dir = cfg.dir;
                  next_motion.speed = cfg.home_speed;
                  if (cfg.method == METH_DSET1 || cfg.method == METH_DSET2) begin
                     finish = 1'b1;
                  end else if (cfg.method == METH_STOP1 || cfg.method == METH_STOP2) begin
                     next_state = ST_PRESS;
                     next_motion.run = 1'b1;
                     next_motion.speed = cfg.creep_speed;
                  end else begin
                     next_state = ST_APPROACH;
                     next_motion.run = 1'b1;
                  end
               end
            end
         end
         ST_APPROACH: begin
            if (act.method == METH_LIMIT && limit_hit) begin
               next_state = ST_SEEK_ZERO;
               next_motion.dir = !act.dir;
               next_motion.speed = act.creep_speed;
            end else if (dog_rise) begin
               next_motion.speed = act.creep_speed; // RULE2
               if (hrs_is_count(act.method)) begin
                  next_state = ST_DOG_TRAVEL; // RULE3
                  next_remain = act.dog_travel;
               end else begin
                  next_state = ST_CREEP;
               end
            end else if (limit_hit && act.retry_en && hrs_retry_ok(act.method)) begin // RULE11
               next_state = ST_RETRY_DWELL; // RULE10
               next_retry_phase = 1'b0;
               next_motion.run = 1'b0;
               dwell_start = 1'b1;
            end
         end
         ST_RETRY_DWELL: begin
            next_motion.run = 1'b0;
            if (dwell_done) begin
               next_motion.run = 1'b1;
               next_motion.speed = act.home_speed;
               if (!retry_phase) begin
                  next_state = ST_RETRY_BACK;
                  next_motion.dir = !act.dir;
                  next_dog_seen = 1'b0;
               end else begin
                  next_state = ST_APPROACH;
                  next_motion.dir = act.dir;
               end
            end
         end
         ST_RETRY_BACK: begin
            if (dog_in) begin
               next_dog_seen = 1'b1;
            end
            if (dog_fall && dog_seen) begin
               next_state = ST_RETRY_DWELL; // RULE10
               next_retry_phase = 1'b1;
               next_motion.run = 1'b0;
               dwell_start = 1'b1;
            end
         end
         ST_CREEP: begin
            next_motion.speed = act.creep_speed; // RULE2
            if (dog_fall) begin
               next_state = ST_SEEK_ZERO;
            end
         end
         ST_DOG_TRAVEL: begin
            next_motion.speed = act.creep_speed;
            if (remain == 32'h0) begin
               next_state = ST_SEEK_ZERO; // RULE3
            end
         end
         ST_SEEK_ZERO: begin
            next_motion.speed = act.creep_speed;
            if (zero_pulse) begin
               if (act.shift_amt != 32'h0 && hrs_shift_ok(act.method)) begin // RULE14
                  next_state = ST_SHIFT;
                  next_motion.dir = !act.shift_amt[31]; // RULE12
                  next_remain = act.shift_amt[31] ? 32'h0 - act.shift_amt : act.shift_amt;
                  next_motion.speed = act.shift_creep ? act.creep_speed
                                                      : act.home_speed; // RULE13
               end else begin
                  finish = 1'b1;
               end
            end
         end
         ST_SHIFT: begin
            if (remain == 32'h0) begin
               finish = 1'b1; // RULE12
            end
         end
         ST_PRESS: begin
            next_tq_en = 1'b1; // RULE15
            next_tq = act.creep_tq;
            if (stall_in) begin
               finish = 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (finish) begin
         next_state = ST_IDLE;
         next_motion.run = 1'b0;
         next_tq_en = 1'b0;
         next_busy = 1'b0;
         next_cur_pos = act.method == METH_DSET1 || act.method == METH_DSET2 ||
                        state == ST_IDLE ? cfg.home_addr : act.home_addr; // RULE1
      end
      next_done = finish;
      next_flag = req_set || (homing_request_flag && !finish);
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= ST_IDLE;
         act <= '0;
         motion <= '0;
         remain <= 32'h0;
         retry_phase <= 1'b0;
         dog_seen <= 1'b0;
         zp_seen <= 1'b0;
         dog_q <= 1'b0;
         limit_q <= 1'b0;
         cur_pos <= POS_RESET;
         torque_lim_en <= 1'b0;
         torque_lim <= TQ_DEFAULT;
         param_block_sel <= PB_RESET;
         homing_request_flag <= FLAG_RESET;
         busy <= 1'b0;
         home_done <= 1'b0;
         seq_err <= 1'b0;
         seq_code <= ERR_NONE;
      end else if (ce) begin
         state <= next_state;
         act <= next_act;
         motion <= next_motion;
         remain <= next_remain;
         retry_phase <= next_retry_phase;
         dog_seen <= next_dog_seen;
         zp_seen <= next_zp_seen;
         dog_q <= dog_in;
         limit_q <= limit_in;
         cur_pos <= next_cur_pos;
         torque_lim_en <= next_tq_en;
         torque_lim <= next_tq;
         param_block_sel <= next_pb;
         homing_request_flag <= next_flag;
         busy <= next_busy;
         home_done <= next_done;
         seq_err <= next_seq_err;
         seq_code <= next_seq_code;
      end
   end

   // Program start gate
   always_comb begin
      next_accept = 1'b0;
      next_gate_err = 1'b0;
      next_err_code = seq_err ? seq_code : err_code;
      if (prog_start) begin
         if (cfg.inhibit_prog && homing_request_flag && !prog_is_homing) begin // RULE16
            next_gate_err = 1'b1; // RULE20
            next_err_code = ERR_NOT_HOMED;
         end else begin
            next_accept = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prog_accept <= 1'b0;
         gate_err <= 1'b0;
         err_code <= ERR_NONE;
      end else if (ce) begin
         prog_accept <= next_accept;
         gate_err <= next_gate_err;
         err_code <= next_err_code;
      end
   end

   assign err_pulse = gate_err || seq_err;

   home_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      home_done && $past(ce) && !$past(act.method == METH_DSET1 || act.method == METH_DSET2)
      |-> cur_pos == act.home_addr) else $error("home address not loaded"); // RULE1
   creep_speed_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && state == ST_APPROACH && dog_rise && !limit_hit
      |=> motion.speed == act.creep_speed) else $error("no creep after dog"); // RULE2
   count_travel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DOG_TRAVEL && remain != 32'h0 |=> state != ST_SEEK_ZERO)
      else $error("zero seek before travel done"); // RULE3
   zpass_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && state == ST_IDLE && home_start && !zp_seen && !cfg.zpass_opt
      |=> state == ST_IDLE && seq_err) else $error("homing without zero pass"); // RULE8
   pblock_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy |-> param_block_sel == act.param_block) else $error("wrong parameter block"); // RULE9
   retry_method_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_RETRY_DWELL |-> hrs_retry_ok(act.method) && !motion.run)
      else $error("retry dwell misuse"); // RULE11
   shift_dir_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_SHIFT |-> motion.dir == !act.shift_amt[31] && hrs_shift_ok(act.method))
      else $error("shift direction wrong"); // RULE12
   torque_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      torque_lim_en |-> $past(state) == ST_PRESS && torque_lim >= TQ_MIN &&
      torque_lim <= TQ_MAX) else $error("torque limit misuse"); // RULE15
   prog_refuse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && prog_start && cfg.inhibit_prog && homing_request_flag && !prog_is_homing
      |=> err_pulse && err_code == ERR_NOT_HOMED && !prog_accept)
      else $error("program not refused"); // RULE20
   flag_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && req_set |=> homing_request_flag) else $error("request flag set lost"); // RULE16
endmodule

// file: hrs_pkg.sv
// Package with constants and types for the home return sequencer
package hrs_pkg;
   // Homing methods
   localparam logic [3:0] METH_DOG1 = 4'h0;
   localparam logic [3:0] METH_CNT1 = 4'h1;
   localparam logic [3:0] METH_DSET1 = 4'h2;
   localparam logic [3:0] METH_DSET2 = 4'h3;
   localparam logic [3:0] METH_DOG2 = 4'h4;
   localparam logic [3:0] METH_CNT2 = 4'h5;
   localparam logic [3:0] METH_CNT3 = 4'h6;
   localparam logic [3:0] METH_CRADLE = 4'h7;
   localparam logic [3:0] METH_STOP1 = 4'h8;
   localparam logic [3:0] METH_STOP2 = 4'h9;
   localparam logic [3:0] METH_LIMIT = 4'ha;
   // Error codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_NOT_HOMED = 8'h79;
   localparam logic [7:0] ERR_NO_ZPHASE = 8'h01;
   localparam logic [7:0] ERR_SPEED = 8'h02;
   // Creep torque limit, percent
   localparam logic [9:0] TQ_MIN = 10'h001;
   localparam logic [9:0] TQ_MAX = 10'h3e8;
   localparam logic [9:0] TQ_DEFAULT = 10'h12c;
   // Speed limits, normal and tenfold rotary mode
   localparam logic [31:0] SPD_MIN = 32'h00000001;
   localparam logic [31:0] SPD_MAX = 32'h00989680;
   localparam logic [31:0] SPD_MAX_X10 = 32'h7fffffff;
   // Reset values
   localparam logic [31:0] POS_RESET = 32'h00000000;
   localparam logic [5:0] PB_RESET = 6'h01;
   localparam logic FLAG_RESET = 1'b1;
   // Dwell timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int DWELL_UNIT_NS = 1000000;
   localparam int CYC_PER_MS_DEF = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [3:0] method;
      logic dir;
      logic [31:0] home_addr;
      logic [31:0] home_speed;
      logic [31:0] creep_speed;
      logic [31:0] dog_travel;
      logic [5:0] param_block;
      logic retry_en;
      logic [12:0] dwell_ms;
      logic [31:0] shift_amt;
      logic shift_creep;
      logic [9:0] creep_tq;
      logic inhibit_prog;
      logic deg_x10;
      logic zpass_opt;
   } hrs_cfg_t;

   typedef struct packed {
      logic run;
      logic dir;
      logic [31:0] speed;
   } hrs_motion_t;
endpackage

// file: hrs_dwell_timer.sv
// Millisecond dwell timer for reversal stops
`timescale 1ns/1ps
module hrs_dwell_timer
   import hrs_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic start,
   input wire logic [12:0] ms,
   output logic done
);
   logic [17:0] cyc;
   logic [12:0] left;
   logic [17:0] next_cyc;
   logic [12:0] next_left;
   localparam logic [17:0] CYC_LAST = 18'(CYC_PER_MS - 1);

   always_comb begin
      next_cyc = cyc;
      next_left = left;
      if (start) begin
         next_cyc = 18'h0;
         next_left = ms;
      end else if (left != 13'h0) begin
         if (cyc == CYC_LAST) begin
            next_cyc = 18'h0;
            next_left = left - 13'h1;
         end else begin
            next_cyc = cyc + 18'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cyc <= 18'h0;
         left <= 13'h0;
      end else if (ce) begin
         cyc <= next_cyc;
         left <= next_left;
      end
   end

   assign done = (left == 13'h0) && !start;
endmodule

// file: hrs_servo_model.sv
// Behavioural servo amplifier: encoder steps, zero phase, dog, limit and stopper
`timescale 1ns/1ps
module hrs_servo_model
   import hrs_pkg::*;
#(
   parameter int REV = 16,
   parameter int DOG_LO = 40,
   parameter int DOG_HI = 60,
   parameter int STALL_POS = 30,
   parameter int LIM_POS = 100,
   parameter int DIV = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire hrs_motion_t motion,
   output logic dog_in,
   output logic limit_in,
   output logic stall_in,
   output logic zero_pulse,
   output logic step_in,
   output logic step_dir,
   output int pos
);
   int div;
   assign dog_in = pos >= DOG_LO && pos <= DOG_HI;
   assign limit_in = pos >= LIM_POS;
   // Stopper sits on the decreasing side and blocks further travel
   assign stall_in = pos <= -STALL_POS;
   always_ff @(posedge clk_sys) begin
      step_in <= 1'b0;
      // Zero phase once per revolution, only when the shaft really turns
      zero_pulse <= step_in && (pos % REV == 0);
      if (!nrst) begin
         pos <= 0;
         div <= 0;
         step_dir <= 1'b1;
      end else if (motion.run && (motion.dir || !stall_in)) begin
         if (div == DIV - 1) begin
            div <= 0;
            step_in <= 1'b1;
            step_dir <= motion.dir;
            pos <= motion.dir ? pos + 1 : pos - 1;
         end else begin
            div <= div + 1;
         end
      end else begin
         div <= 0;
      end
   end
endmodule

// file: testbench.sv
// Self-checking testbench for the home return sequencer
`timescale 1ns/1ps
module testbench
   import hrs_pkg::*;
   ;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   hrs_cfg_t cfg = '0;
   logic home_start = 1'b0;
   logic req_set = 1'b0;
   logic prog_start = 1'b0;
   logic prog_is_homing = 1'b0;
   logic dog_in, limit_in, zero_pulse, stall_in, step_in, step_dir;
   hrs_motion_t motion;
   logic [5:0] param_block_sel;
   logic torque_lim_en, busy, home_done, prog_accept, err_pulse, homing_request_flag;
   logic [9:0] torque_lim;
   logic [31:0] cur_pos;
   logic [7:0] err_code;
   int srv_pos;
   int failures = 0;
   int comparisons = 0;
   logic tq_seen;
   logic dw_seen;

   always #2.5 clk_sys = ~clk_sys;

   hrs_home_return #(.CYC_PER_MS(4)) hrs_home_return_inst (
      .clk_sys, .nrst, .ce, .cfg, .home_start, .dog_in, .limit_in, .zero_pulse,
      .stall_in, .step_in, .step_dir, .req_set, .prog_start, .prog_is_homing,
      .motion, .param_block_sel, .torque_lim_en, .torque_lim, .cur_pos,
      .homing_request_flag, .busy, .home_done, .prog_accept, .err_pulse, .err_code
   );

   hrs_servo_model hrs_servo_model_inst (
      .clk_sys, .nrst, .motion, .dog_in, .limit_in, .stall_in, .zero_pulse,
      .step_in, .step_dir, .pos(srv_pos)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Reset both sides and load a plain configuration
   task automatic restart(input logic [3:0] meth);
      nrst = 1'b0;
      cfg = '0;
      cfg.method = meth;
      cfg.dir = 1'b1;
      cfg.home_speed = 32'h00000064;
      cfg.creep_speed = 32'h0000000a;
      cfg.param_block = 6'h05;
      cfg.creep_tq = 10'h1f4;
      cfg.zpass_opt = 1'b1;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
   endtask

   task automatic kick();
      home_start = 1'b1;
      @(negedge clk_sys);
      home_start = 1'b0;
   endtask

   // Start homing and watch the run until completion
   task automatic run_home();
      int n;
      n = 0;
      tq_seen = 1'b0;
      dw_seen = 1'b0;
      kick();
      while (home_done !== 1'b1 && n < 2000) begin
         if (busy === 1'b1)
            check("pblock", param_block_sel, cfg.param_block);
         if (busy === 1'b1 && motion.run === 1'b0)
            dw_seen = 1'b1;
         if (motion.run === 1'b1 && motion.dir === cfg.dir && dog_in && srv_pos > 41 &&
             !cfg.method[0])
            check("creep", motion.speed, cfg.creep_speed);
         if (motion.run === 1'b1 && srv_pos > 64 && cfg.shift_amt != 32'h0)
            check("shift speed", motion.speed, cfg.creep_speed);
         if (torque_lim_en === 1'b1) begin
            tq_seen = 1'b1;
            check("torque", torque_lim, cfg.creep_tq != 0 ? cfg.creep_tq : TQ_DEFAULT);
         end
         @(negedge clk_sys);
         n++;
      end
      check("done", home_done, 1'b1);
      check("home pos", cur_pos, cfg.home_addr);
      check("flag", homing_request_flag, 1'b0);
   endtask

   task automatic prog(input logic inh, input logic hm, input logic acc);
      cfg.inhibit_prog = inh;
      prog_is_homing = hm;
      prog_start = 1'b1;
      @(negedge clk_sys);
      prog_start = 1'b0;
      check("accept", prog_accept, acc);
      check("refuse", err_pulse, !acc);
      if (!acc)
         check("code 121", err_code, ERR_NOT_HOMED);
      @(negedge clk_sys);
   endtask

   task automatic t_reset();
      restart(METH_DOG1);
      check("flag rst", homing_request_flag, 1'b1);
      check("pos rst", cur_pos, 32'h0);
      check("tq rst", torque_lim, TQ_DEFAULT);
      check("pb rst", param_block_sel, 6'h01);
      check("err rst", err_code, ERR_NONE);
      cfg.zpass_opt = 1'b0;
      kick();
      check("no zero", err_pulse, 1'b1);
      @(negedge clk_sys);
      check("no zero code", err_code, ERR_NO_ZPHASE);
      check("no zero idle", busy, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_prog();
      restart(METH_DOG1);
      prog(1'b1, 1'b0, 1'b0);
      prog(1'b1, 1'b1, 1'b1);
      prog(1'b0, 1'b0, 1'b1);
      ce = 1'b0;
      prog_start = 1'b1;
      @(negedge clk_sys);
      prog_start = 1'b0;
      check("ce hold", prog_accept, 1'b0);
      check("ce hold err", err_pulse, 1'b0);
      ce = 1'b1;
      $display("test program gate done");
   endtask

   task automatic t_dog();
      restart(METH_DOG1);
      cfg.home_addr = 32'h00001234;
      run_home();
      check("dog stop", srv_pos, 64);
      check("no dwell", dw_seen, 1'b0);
      prog(1'b1, 1'b0, 1'b1);
      req_set = 1'b1;
      @(negedge clk_sys);
      req_set = 1'b0;
      check("flag set", homing_request_flag, 1'b1);
      prog(1'b1, 1'b0, 1'b0);
      // Second run starts past the dog, so the limit turns it back
      cfg.retry_en = 1'b1;
      cfg.dwell_ms = 13'h0002;
      run_home();
      check("retry dwell", dw_seen, 1'b1);
      check("retry stop", srv_pos, 64);
      $display("test dog done");
   endtask

   task automatic t_count();
      logic [31:0] sh [2] = '{32'h00000005, 32'hfffffffd};
      int fin [2] = '{69, 61};
      for (int i = 0; i < 2; i++) begin
         restart(METH_CNT1);
         cfg.dog_travel = 32'h0000000a;
         cfg.shift_amt = sh[i];
         cfg.shift_creep = 1'b1;
         cfg.home_addr = 32'hfffffff0;
         run_home();
         check("count pos", srv_pos, fin[i]);
      end
      $display("test count done");
   endtask

   task automatic t_dset();
      restart(METH_DSET1);
      cfg.home_addr = 32'h00000055;
      cfg.shift_amt = 32'h00000007;
      run_home();
      repeat (8) @(negedge clk_sys);
      check("dset no move", srv_pos, 0);
      $display("test data set done");
   endtask

   task automatic t_stop();
      logic [9:0] tq [2] = '{10'h1f4, 10'h000};
      for (int i = 0; i < 2; i++) begin
         restart(METH_STOP1);
         cfg.dir = 1'b0;
         cfg.creep_tq = tq[i];
         cfg.shift_amt = 32'h00000009;
         run_home();
         check("tq seen", tq_seen, 1'b1);
         check("stop pos", srv_pos, -30);
      end
      $display("test stopper done");
   endtask

   task automatic t_speed();
      restart(METH_DOG1);
      cfg.home_speed = 32'h00989681;
      kick();
      @(negedge clk_sys);
      check("spd refuse", err_code, ERR_SPEED);
      check("spd idle", busy, 1'b0);
      cfg.deg_x10 = 1'b1;
      kick();
      check("spd x10", busy, 1'b1);
      $display("test speed range done");
   endtask

   initial begin
      t_reset();
      t_prog();
      t_dog();
      t_count();
      t_dset();
      t_stop();
      t_speed();
      close_out();
   end

   // Whole run needs under two thousand cycles; this allows about 20000
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule
